// ---- rtl/cs_decode.sv ----
// Chip select configuration, address decode and DRAM init sequencing.
// Assumes an APB master on clock and a CPU access strobe on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cs_decode (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic access_req,
  input wire logic [23:0] access_addr,
  output logic [3:0] cs_select,
  output logic access_ready,
  output logic load_mode_access,
  output logic [2:0] dram_cmd,
  output logic irq
);
  localparam logic [2:0] wait_zero = 3'h0;

  logic [7:0] size_mode_reg [4];
  logic [7:0] ctrl_b_reg [4];
  logic [15:0] base_reg [4];
  logic [13:0] delay_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic init_done_reg;
  logic [13:0] delay_cnt_reg;
  logic [2:0] wait_cnt_reg;
  logic waiting_reg, rd_valid_reg;
  logic [2:0] dram_cmd_reg;
  logic self_ref_active_reg;
  logic [3:0] hits;
  logic wr_en, rd_en, addr_ok;
  logic [9:0] word;
  logic [7:0] rd_byte;
  logic [15:0] rd_half;
  logic dram_on;
  logic done_event, select_event;
  cs_decode_pkg::dram_cmd_t step_reg;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic [1:0] mode_of(input logic [7:0] v);
    mode_of = v[cs_decode_pkg::mode_lsb +: 2];
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_match
      cs_window_match u_match (
        .addr(access_addr),
        .base(base_reg[gi]),
        .size(size_mode_reg[gi][cs_decode_pkg::size_lsb +: 5]),
        .mode(mode_of(size_mode_reg[gi])),
        .hit(hits[gi])
      );
    end
  endgenerate

  assign dram_on = mode_of(size_mode_reg[3]) == 2'b11; // R5

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign word = paddr[11:2];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // Reads take one wait state so registered prdata stands at the pready edge
  assign pready = pwrite || rd_valid_reg;

  always_comb begin
    addr_ok = 1'b1;
    rd_byte = 8'h00;
    rd_half = 16'h0000;
    if (word[9:4] == 6'h01) begin
      if (word[1:0] == cs_decode_pkg::off_size_mode[1:0]) begin
        rd_byte = size_mode_reg[word[3:2]] & cs_decode_pkg::size_mode_mask;
      end else if (word[1:0] == cs_decode_pkg::off_ctrl_b[1:0]) begin
        if (word[3:2] == 2'd3 && dram_on) begin
          rd_byte = {init_done_reg, 4'h0, ctrl_b_reg[3][2:0]}; // R7 R12
        end else begin
          rd_byte = ctrl_b_reg[word[3:2]] & cs_decode_pkg::wait_mask; // R12
        end
      end else if (word[1:0] == cs_decode_pkg::off_base[1:0]) begin
        rd_half = base_reg[word[3:2]] & cs_decode_pkg::base_mask; // R12
      end else begin
        addr_ok = 1'b0;
      end
    end else if (word == 10'(cs_decode_pkg::off_irq_status)) begin
      rd_byte = {6'h00, status_reg};
    end else if (word == 10'(cs_decode_pkg::off_irq_mask)) begin
      rd_byte = {6'h00, mask_reg};
    end else if (word == 10'(cs_decode_pkg::off_startup_delay)) begin
      rd_half = {2'b00, delay_reg};
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && pready && !addr_ok;

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_en && !rd_valid_reg;
      if (rd_en && !rd_valid_reg) begin
        prdata <= {16'h0000, rd_half | {8'h00, rd_byte}};
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        size_mode_reg[i] <= cs_decode_pkg::reg_rst;
        ctrl_b_reg[i] <= cs_decode_pkg::reg_rst;
        base_reg[i] <= cs_decode_pkg::base_rst;
      end
      delay_reg <= cs_decode_pkg::startup_delay_rst;
      mask_reg <= 2'b00;
    end else if (wr_en && addr_ok) begin
      if (word[9:4] == 6'h01) begin
        if (word[1:0] == cs_decode_pkg::off_size_mode[1:0]) begin
          size_mode_reg[word[3:2]] <= pwdata[7:0] & cs_decode_pkg::size_mode_mask;
          if (word[3:2] != 2'd3 && pwdata[1:0] == 2'b11) begin
            // Keep previous mode, DRAM refused here
            size_mode_reg[word[3:2]][1:0] <= size_mode_reg[word[3:2]][1:0]; // R6
          end
        end else if (word[1:0] == cs_decode_pkg::off_ctrl_b[1:0]) begin
          ctrl_b_reg[word[3:2]] <= pwdata[7:0] & cs_decode_pkg::dram_wr_mask; // R10 R11
        end else if (word[1:0] == cs_decode_pkg::off_base[1:0]) begin
          base_reg[word[3:2]] <= pwdata[15:0] & cs_decode_pkg::base_mask; // R4
        end
      end else if (word == 10'(cs_decode_pkg::off_irq_mask)) begin
        mask_reg <= pwdata[1:0];
      end else if (word == 10'(cs_decode_pkg::off_startup_delay)) begin
        delay_reg <= pwdata[13:0];
      end
    end
  end

  // ------------------------------------------------------------
  // DRAM init sequence and self-refresh
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst || !dram_on) begin
      step_reg <= cs_decode_pkg::dram_none;
      delay_cnt_reg <= 14'h0000;
      init_done_reg <= 1'b0; // R9
      dram_cmd_reg <= 3'(cs_decode_pkg::dram_none);
      self_ref_active_reg <= 1'b0;
    end else begin
      dram_cmd_reg <= 3'(cs_decode_pkg::dram_none);
      case (step_reg)
        cs_decode_pkg::dram_none: begin
          if (!init_done_reg) begin
            if (delay_cnt_reg >= delay_reg) begin
              step_reg <= cs_decode_pkg::dram_precharge; // R13
            end else begin
              delay_cnt_reg <= delay_cnt_reg + 14'h0001;
            end
          end else if (ctrl_b_reg[3][2] != self_ref_active_reg) begin
            self_ref_active_reg <= ctrl_b_reg[3][2];
            dram_cmd_reg <= ctrl_b_reg[3][2] ? // R10
              3'(cs_decode_pkg::dram_self_refresh) :
              3'(cs_decode_pkg::dram_exit_self_refresh);
          end
        end
        cs_decode_pkg::dram_precharge: begin
          dram_cmd_reg <= 3'(cs_decode_pkg::dram_precharge); // R13
          step_reg <= cs_decode_pkg::dram_refresh;
        end
        cs_decode_pkg::dram_refresh: begin
          dram_cmd_reg <= 3'(cs_decode_pkg::dram_refresh); // R13
          step_reg <= cs_decode_pkg::dram_load_mode;
        end
        default: begin
          dram_cmd_reg <= 3'(cs_decode_pkg::dram_load_mode); // R13
          init_done_reg <= 1'b1; // R9
          step_reg <= cs_decode_pkg::dram_none;
        end
      endcase
    end
  end

  assign dram_cmd = dram_cmd_reg;

  // ------------------------------------------------------------
  // Access timing with wait states
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_cnt_reg <= wait_zero;
      waiting_reg <= 1'b0;
      cs_select <= 4'h0;
      load_mode_access <= 1'b0;
    end else begin
      load_mode_access <= 1'b0;
      if (!waiting_reg && access_req) begin
        cs_select <= hits; // R14
        waiting_reg <= 1'b1;
        wait_cnt_reg <= wait_zero;
        load_mode_access <= hits[3] && dram_on &&
          ctrl_b_reg[3][1:0] == 2'b01; // R11
      end else if (waiting_reg) begin
        if (access_ready) begin
          waiting_reg <= 1'b0;
          cs_select <= 4'h0;
        end else begin
          wait_cnt_reg <= wait_cnt_reg + 3'h1; // R8
        end
      end
    end
  end

  always_comb begin
    access_ready = 1'b0;
    if (waiting_reg) begin
      access_ready = 1'b1;
      for (int i = 0; i < 3; i++) begin
        if (cs_select[i] && wait_cnt_reg < ctrl_b_reg[i][2:0]) begin
          access_ready = 1'b0; // R8
        end
      end
      if (cs_select[3] && !dram_on &&
          wait_cnt_reg < ctrl_b_reg[3][2:0]) begin
        access_ready = 1'b0; // R7 R8
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupts: bit0 init done, bit1 access selected
  // ------------------------------------------------------------
  assign done_event = (step_reg == cs_decode_pkg::dram_load_mode) && dram_on;
  assign select_event = !waiting_reg && access_req && (hits != 4'h0);

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= 2'b00;
    end else begin
      if (wr_en && word == 10'(cs_decode_pkg::off_irq_status)) begin
        status_reg <= (status_reg & ~pwdata[1:0]) |
          {select_event, done_event};
      end else begin
        status_reg <= status_reg | {select_event, done_event};
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_non_dram_mode;
    @(posedge clock) disable iff (rst)
      mode_of(size_mode_reg[0]) != 2'b11;
  endproperty
  a_non_dram_mode: assert property (p_non_dram_mode) // R6
    else $error("chip select zero in DRAM mode");

  property p_done_order;
    @(posedge clock) disable iff (rst)
      $rose(init_done_reg) |-> $past(dram_cmd_reg) ==
        3'(cs_decode_pkg::dram_refresh);
  endproperty
  a_done_order: assert property (p_done_order) // R13
    else $error("init done without refresh before load");

  property p_done_drop;
    @(posedge clock) disable iff (rst)
      !dram_on |=> !init_done_reg;
  endproperty
  a_done_drop: assert property (p_done_drop) // R9
    else $error("init flag kept outside DRAM mode");

  property p_disabled_no_hit;
    @(posedge clock) disable iff (rst)
      mode_of(size_mode_reg[1]) == 2'b00 |-> !hits[1];
  endproperty
  a_disabled_no_hit: assert property (p_disabled_no_hit) // R5
    else $error("disabled chip select hit");

  property p_wait_states;
    @(posedge clock) disable iff (rst)
      access_req && !waiting_reg && hits == 4'h1 &&
        ctrl_b_reg[0][2:0] == 3'h2 |=> !access_ready [*2] ##1 access_ready;
  endproperty
  a_wait_states: assert property (p_wait_states) // R8
    else $error("wrong wait count");

  property p_base_res;
    @(posedge clock) disable iff (rst)
      base_reg[2][3:0] == 4'h0;
  endproperty
  a_base_res: assert property (p_base_res) // R12
    else $error("base reserved bits set");

  property p_full_window;
    @(posedge clock) disable iff (rst)
      size_mode_reg[3][6:2] == 5'h10 && mode_of(size_mode_reg[3]) != 2'b00
        |-> hits[3];
  endproperty
  a_full_window: assert property (p_full_window) // R1 R2
    else $error("16M window missed");

  property p_self_ref;
    @(posedge clock) disable iff (rst)
      init_done_reg && dram_on && step_reg == cs_decode_pkg::dram_none &&
        $rose(ctrl_b_reg[3][2]) |=> dram_cmd_reg ==
        3'(cs_decode_pkg::dram_self_refresh);
  endproperty
  a_self_ref: assert property (p_self_ref) // R10
    else $error("no self refresh command");
endmodule
`default_nettype wire

// ---- rtl/cs_decode_pkg.sv ----
// Constants for the chip select decode block: register map, fields, timing.
// Assumes a 32-bit APB slave, 50 MHz clock, four chip selects.
//
// What this block does
// R1 - Five-bit window size: 256 bytes doubling to 16M; other codes reserved.
// R2 - Compare address bits from window size upward to bit 23; 16M compares none.
// R3 - Region extends upward from base by the window size.
// R4 - Base register bits 15:4 hold address bits 23:12 of region start.
// R5 - Mode 00 disabled, 01 static, 10 multiplexed static, 11 DRAM.
// R6 - DRAM mode only accepted on chip select three.
// R7 - Second control register layout depends on interface mode.
// R8 - Static modes insert 0 to 7 wait cycles as coded.
// R9 - Init-complete flag set at init end, held while DRAM mode stays on.
// R10 - Self-refresh bit one sends self-refresh; zero leaves it.
// R11 - DRAM access mode 00 normal, 01 load mode register, others reserved.
// R12 - Reserved bits of control and base registers read as zero.
// R13 - After startup delay: precharge all, auto-refresh, load mode, then done.
// R14 - Select only when enabled and compared address bits match base.
package cs_decode_pkg;
  localparam int num_cs = 4;
  localparam int dram_cs = 3;
  // Per chip select register indices, four per chip select
  localparam logic [7:0] off_size_mode = 8'h00;
  localparam logic [7:0] off_ctrl_b = 8'h01;
  localparam logic [7:0] off_base = 8'h02;
  localparam logic [7:0] cs_stride = 8'h04;
  localparam logic [7:0] cs_first = 8'h10;
  // Block-wide registers
  localparam logic [7:0] off_irq_status = 8'h20;
  localparam logic [7:0] off_irq_mask = 8'h21;
  localparam logic [7:0] off_startup_delay = 8'h22;
  // Field positions
  localparam int mode_lsb = 0;
  localparam int size_lsb = 2;
  localparam int wait_lsb = 0;
  localparam int access_lsb = 0;
  localparam int self_refresh_bit = 2;
  localparam int init_done_bit = 7;
  localparam int base_lsb = 4;
  localparam logic [4:0] size_max = 5'h10;
  localparam logic [7:0] size_mode_mask = 8'h7f;
  localparam logic [7:0] wait_mask = 8'h07;
  localparam logic [7:0] dram_wr_mask = 8'h07;
  localparam logic [15:0] base_mask = 16'hfff0;
  localparam logic [13:0] startup_delay_rst = 14'h0000;
  localparam logic [7:0] reg_rst = 8'h00;
  localparam logic [15:0] base_rst = 16'h0000;
  // Doubled peripheral clock equals the block clock here
  localparam int clk_mhz = 50;
  localparam int dram_cmd_ns = 20;
  localparam int dram_cmd_cycles =
    (dram_cmd_ns * clk_mhz + 999) / 1000;
  typedef enum logic [1:0] {
    mode_disabled, mode_static, mode_multiplexed_static, mode_dram
  } cs_mode_t;
  typedef enum logic [2:0] {
    dram_none, dram_precharge, dram_refresh, dram_load_mode, dram_self_refresh,
    dram_exit_self_refresh
  } dram_cmd_t;
endpackage

// ---- rtl/cs_window_match.sv ----
// One chip select address comparator.
// Assumes registered configuration on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cs_window_match (
  input wire logic [23:0] addr,
  input wire logic [15:0] base,
  input wire logic [4:0] size,
  input wire logic [1:0] mode,
  output logic hit
);
  logic [23:0] cmp_mask;
  always_comb begin
    // Window of 256 bytes shifted up by the size code
    cmp_mask = 24'hffffff << (5'd8 + size); // R1 R2 R3
    if (size >= cs_decode_pkg::size_max) begin
      cmp_mask = 24'h000000; // R2
    end
    hit = (mode != 2'b00) &&
      (((addr ^ {base[15:4], 12'h000}) & cmp_mask) == 24'h000000); // R4 R14
  end
endmodule
`default_nettype wire

// ---- sim/cs_decode_tb.sv ----
// Self-checking bench for the chip select decode block.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module cs_decode_tb;
  typedef struct {
    int cs;
    logic [7:0] sm;
    logic [15:0] base;
    logic [2:0] ws;
    logic [23:0] a;
    logic [3:0] sel;
  } row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, access_req = 1'b0;
  logic [23:0] access_addr = 24'h0;
  logic [3:0] cs_select, sel;
  logic access_ready, load_mode_access, irq, err;
  logic [2:0] dram_cmd;
  logic init_ok, self_ref;
  logic [7:0] n_load;
  logic [31:0] q;
  int mismatches = 0;
  int n_tests = 0;
  int waits, k;
  row_t rows[8];
  always #10 clock = ~clock;
  cs_decode u_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .access_req(access_req), .access_addr(access_addr),
    .cs_select(cs_select), .access_ready(access_ready),
    .load_mode_access(load_mode_access), .dram_cmd(dram_cmd), .irq(irq));
  dram_model u_mem (.clock(clock), .rst(rst), .dram_cmd(dram_cmd),
    .load_mode_access(load_mode_access), .init_ok(init_ok),
    .self_ref(self_ref), .n_load(n_load));
  // ----------------------------------------
  // Bus, access and compare tasks
  // ----------------------------------------
  function automatic logic [11:0] ra(input int cs, input int r);
    return 12'((cs_decode_pkg::cs_first + cs * 4 + r) * 4);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    err = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  task automatic acc(input logic [23:0] a);
    @(posedge clock);
    access_req <= 1'b1;
    access_addr <= a;
    @(posedge clock);
    #1 sel = cs_select;
    waits = 0;
    while (access_ready !== 1'b1) begin
      @(posedge clock);
      #1 waits++;
    end
    @(posedge clock);
    access_req <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{0, 8'h01, 16'h0010, 3'h2, 24'h0010ff, 4'h1},
             '{0, 8'h01, 16'h0010, 3'h0, 24'h001100, 4'h0},
             '{1, 8'h3e, 16'h8000, 3'h7, 24'hffffff, 4'h2},
             '{1, 8'h3e, 16'h8000, 3'h7, 24'h7fffff, 4'h0},
             '{2, 8'h11, 16'h1230, 3'h3, 24'h123fff, 4'h4},
             '{2, 8'h11, 16'h1230, 3'h3, 24'h124000, 4'h0},
             '{2, 8'h10, 16'h1230, 3'h3, 24'h123000, 4'h0},
             '{3, 8'h41, 16'h0000, 3'h5, 24'habcdef, 4'h8}};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, ra(0, 0), 32'h0);
    chk("rst_mode", q, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, ra(rows[i].cs, 0), {24'h0, rows[i].sm | 8'h80});
      apb(1'b1, ra(rows[i].cs, 1), {24'h0, 5'h1f, rows[i].ws});
      apb(1'b1, ra(rows[i].cs, 2), {16'h0, rows[i].base | 16'h000f});
      apb(1'b0, ra(rows[i].cs, 0), 32'h0);
      chk("mode_reg", q, {24'h0, rows[i].sm});
      apb(1'b0, ra(rows[i].cs, 1), 32'h0);
      chk("wait_reg", q, {29'h0, rows[i].ws});
      apb(1'b0, ra(rows[i].cs, 2), 32'h0);
      chk("base_reg", q, {16'h0, rows[i].base});
      acc(rows[i].a);
      chk("select", {28'h0, sel}, {28'h0, rows[i].sel});
      if (rows[i].sel != 4'h0)
        chk("waits", waits, rows[i].ws);
      apb(1'b1, ra(rows[i].cs, 0), 32'h0);
    end
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b0, 12'h080, 32'h0);
    chk("status", q, 32'h2);
    apb(1'b1, 12'h084, 32'h2);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h080, 32'h2);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, ra(0, 0), 32'h0b);
    apb(1'b0, ra(0, 0), 32'h0);
    chk("no_dram_cs0", q, 32'h08);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h088, 32'h3);
    apb(1'b1, 12'h084, 32'h1);
    apb(1'b1, ra(3, 1), 32'h0);
    apb(1'b1, ra(3, 0), 32'h43);
    for (k = 0; k < 60 && init_ok !== 1'b1; k++) @(posedge clock);
    chk("init_seq", {31'h0, init_ok}, 32'h1);
    apb(1'b0, ra(3, 1), 32'h0);
    chk("init_flag", q, 32'h80);
    chk("irq_init", {31'h0, irq}, 32'h1);
    apb(1'b1, ra(3, 1), 32'h04);
    for (k = 0; k < 20 && self_ref !== 1'b1; k++) @(posedge clock);
    chk("self_ref", {31'h0, self_ref}, 32'h1);
    apb(1'b0, ra(3, 1), 32'h0);
    chk("ctrl_b", q, 32'h84);
    apb(1'b1, ra(3, 1), 32'h01);
    for (k = 0; k < 20 && self_ref !== 1'b0; k++) @(posedge clock);
    chk("self_exit", {31'h0, self_ref}, 32'h0);
    acc(24'h000100);
    chk("dram_sel", {28'h0, sel}, 32'h8);
    for (k = 0; k < 5 && n_load !== 8'h01; k++) @(posedge clock);
    chk("load_mode", {24'h0, n_load}, 32'h1);
    apb(1'b1, 12'h080, 32'h1);
    chk("irq_w1c", {31'h0, irq}, 32'h0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, ra(3, 1), 32'h0);
    chk("rst_flag", q, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// ---- sim/dram_model.sv ----
// Far-side memory model: watches the command strobes of the block.
// Assumes the block clock and its synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module dram_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] dram_cmd,
  input wire logic load_mode_access,
  output logic init_ok,
  output logic self_ref,
  output logic [7:0] n_load
);
  logic [1:0] step;
  // ----------------------------------------
  // Init order: precharge, refresh, load mode
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      step <= 2'h0;
      init_ok <= 1'b0;
      self_ref <= 1'b0;
      n_load <= 8'h00;
    end else begin
      step <= 2'h0;
      case (dram_cmd)
        3'h1: step <= 2'h1;
        3'h2: step <= (step == 2'h1) ? 2'h2 : 2'h0;
        3'h3: init_ok <= init_ok | (step == 2'h2);
        3'h4: self_ref <= 1'b1;
        3'h5: self_ref <= 1'b0;
        default: ;
      endcase
      if (load_mode_access) begin
        n_load <= n_load + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
